//--- acp_fifo.sv
`timescale 1ns/100ps
module acp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,   // system clock
   input  wire logic             rstn,    // synchronous reset, low
   input  wire logic             inValid, // write request
   output logic                  inReady, // room available
   input  wire logic [WIDTH-1:0] inData,  // write word
   output logic                  outValid,// word available
   input  wire logic             outReady,// drain request
   output logic      [WIDTH-1:0] outData, // head word
   output logic [$clog2(DEPTH):0] level   // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   wire              doWr = inValid && inReady;
   wire              doRd = outValid && outReady;
   assign inReady  = (count_r < (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem[rdPtr_r];
   assign level    = count_r;
   always_ff @(posedge clock) begin
      if (doWr) begin
         mem[wrPtr_r] <= inData;
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         wrPtr_r <= doWr ? wrPtr_r + 1'b1 : wrPtr_r;
         rdPtr_r <= doRd ? rdPtr_r + 1'b1 : rdPtr_r;
         count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule : acp_fifo

//--- acp_host_model.sv
`timescale 1ns/100ps
module acp_host_model (
   input  wire logic       clock,    // system clock
   output logic      [3:0] addr,     // register offset
   output logic            rdStrobe, // read pulse
   output logic            wrStrobe, // write pulse
   output logic      [7:0] wrData,   // write byte
   input  wire logic [7:0] rdData    // read byte
);
   initial begin
      addr     = 4'h0;
      rdStrobe = 1'b0;
      wrStrobe = 1'b0;
      wrData   = 8'h00;
   end
   // Released data is inverted so a stale byte is never taken for a fresh one.
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr     <= a;
      wrData   <= d;
      wrStrobe <= 1'b1;
      @(posedge clock);
      wrStrobe <= 1'b0;
      wrData   <= ~d;
   endtask : write_reg
   task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr     <= a;
      rdStrobe <= 1'b1;
      @(posedge clock);
      rdStrobe <= 1'b0;
      @(posedge clock);
      d = rdData;
   endtask : read_reg
   task automatic write_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         write_reg(4'h6, w[8*i +: 8]);
      end
   endtask : write_word
endmodule : acp_host_model

//--- acp_host_port.sv
`timescale 1ns/100ps
module acp_host_port (
   input  wire logic        clock,         // system clock, 100 MHz
   input  wire logic        rstn,          // synchronous reset, low
   input  wire logic [3:0]  addr,          // register offset
   input  wire logic        rdStrobe,      // one-cycle read
   input  wire logic        wrStrobe,      // one-cycle write
   input  wire logic [7:0]  wrData,        // write byte
   output logic      [7:0]  rdData,        // read byte, registered
   input  wire logic [5:0]  indirectIndex, // indirect index field
   output logic             indWrite,      // pulse: commit indirect pair
   output logic      [5:0]  indAddr,       // indirect address
   output logic      [15:0] indData,       // indirect word
   input  wire logic [15:0] indReadData,   // indirect readback
   input  wire logic        gameEvt,       // game data ready pulse
   input  wire logic        ringPin,       // ring input pin, async
   input  wire logic        volEvt,        // volume button pulse
   input  wire logic        timerEvt,      // timer count pulse
   input  wire logic        capCntEvt,     // capture count pulse
   input  wire logic        playCntEvt,    // playback count pulse
   input  wire logic        samplePeriod,  // sample clock tick
   input  wire logic [1:0]  leftLevel,     // ADC left level code
   input  wire logic [1:0]  rightLevel,    // ADC right level code
   input  wire logic        powerDown,     // chip power down
   input  wire logic        capValid,      // capture word offered
   output logic             capReady,      // capture path ready
   input  wire logic [31:0] capWord,       // capture word
   output logic      [15:0] dacLeft,       // DAC left sample
   output logic      [15:0] dacRight,      // DAC right sample
   output logic             dmaRequest,    // playback DMA request
   output logic      [7:0]  intFlags       // interrupt flags
);
   logic [7:0]  flags_r, flags_nxt;
   logic [7:0]  lowTmp_r;
   logic [7:0]  debug_r;
   logic [7:0]  cfg_r;
   logic        ringS1_r, ringS2_r, ringS3_r;
   logic        capOver_r, playUnder_r;
   logic        capLoaded_r;
   logic [31:0] capHold_r;
   logic [31:0] playAsm_r;
   logic        playFull_r;
   logic [31:0] lastWord_r;
   logic [1:0]  capIdx_r, playIdx_r;
   acp_pkg::acp_byte_e capSt_r, playSt_r;
   logic [15:0] dacL_r, dacR_r;
   logic [7:0]  rd_r;
   wire         playback_enable     = cfg_r[0];
   wire         pPio    = cfg_r[1];
   wire         pStereo = cfg_r[2];
   wire [2:0]   fmtCode = {cfg_r[5:4], cfg_r[3]};
   wire         dacZero = cfg_r[6];
   wire         reqDis  = cfg_r[7];
   wire         wide    = (fmtCode == acp_pkg::FMT_S16LE);
   wire         wr      = wrStrobe;
   wire         isData  = (addr == acp_pkg::OFF_DATA);
   wire         capRd   = rdStrobe && isData;
   wire         playWr  = wrStrobe && isData;
   wire         ringRise = ringS2_r && !ringS3_r;
   // Capture FIFO: filled by the ADC side, drained by the host.
   logic        cfOutValid, cfOutReady, cfInReady;
   logic [31:0] cfOut;
   logic [3:0]  cfLevel;
   acp_fifo #(.WIDTH(acp_pkg::FIFO_WIDTH), .DEPTH(acp_pkg::FIFO_WORDS)) capFifo (
      .clock(clock), .rstn(rstn),
      .inValid(capValid && !capOver_r), .inReady(cfInReady), .inData(capWord),
      .outValid(cfOutValid), .outReady(cfOutReady), .outData(cfOut),
      .level(cfLevel));
   // Overrun discards new data, so the source is always accepted then.
   assign capReady = cfInReady || capOver_r;
   wire capLast = (capIdx_r == 2'd3);
   wire capDone = capRd && capLast;
   assign cfOutReady = !capLoaded_r || capDone;
   // Playback FIFO: filled by host words, drained each sample period while playback_enable is set.
   logic        pfInReady, pfOutValid;
   logic [31:0] pfOut;
   logic [3:0]  pfLevel;
   wire         pfPush = playFull_r && pfInReady;
   wire         pfPop  = samplePeriod && playback_enable;
   acp_fifo #(.WIDTH(acp_pkg::FIFO_WIDTH), .DEPTH(acp_pkg::FIFO_WORDS)) playFifo (
      .clock(clock), .rstn(rstn),
      .inValid(playFull_r), .inReady(pfInReady), .inData(playAsm_r),
      .outValid(pfOutValid), .outReady(pfPop), .outData(pfOut),
      .level(pfLevel));
   // Flags: any clear from the host loses to a same-cycle event.
   always_comb begin
      flags_nxt = flags_r;
      if (wr && addr == acp_pkg::OFF_INT_FLAGS) begin
         flags_nxt = flags_r & wrData;
      end
      flags_nxt[acp_pkg::BIT_GAME] = flags_nxt[acp_pkg::BIT_GAME] | gameEvt;
      flags_nxt[acp_pkg::BIT_CALL] = flags_nxt[acp_pkg::BIT_CALL] | ringRise;
      flags_nxt[acp_pkg::BIT_VOL]  = flags_nxt[acp_pkg::BIT_VOL] | volEvt;
      flags_nxt[acp_pkg::BIT_DSP]  = flags_nxt[acp_pkg::BIT_DSP] |
         (indWrite && indAddr == acp_pkg::DSP_CFG_INDEX &&
          indData[acp_pkg::DSP_TRIG_BIT]);
      flags_nxt[acp_pkg::BIT_TMR]  = flags_nxt[acp_pkg::BIT_TMR] | timerEvt;
      flags_nxt[acp_pkg::BIT_CAP]  = flags_nxt[acp_pkg::BIT_CAP] | capCntEvt;
      flags_nxt[acp_pkg::BIT_PLAY] = flags_nxt[acp_pkg::BIT_PLAY] | playCntEvt;
   end
   assign intFlags = flags_r;
   assign indWrite = wr && addr == acp_pkg::OFF_IND_HIGH;
   assign indAddr  = indirectIndex;
   assign indData  = {wrData, lowTmp_r};
   // Status composition.
   wire capHalf = wide ? capIdx_r[0] : 1'b1;
   wire capSide = !pStereo || !(wide ? capIdx_r[1] : capIdx_r[0]);
   wire capReadyBit = capLoaded_r;
   wire plHalf  = wide ? playIdx_r[0] : 1'b1;
   wire plSide  = !pStereo || !(wide ? playIdx_r[1] : playIdx_r[0]);
   wire [3:0] cfRoom = 4'(acp_pkg::FIFO_WORDS) - cfLevel;
   wire [7:0] statusByte = {!pfInReady ? 1'b0 : (pfLevel < 4'd4), pfInReady, // space flags
                            plSide, plHalf,
                            ({cfRoom, 2'b00} >= acp_pkg::HALF_ROOM_BYTES),
                            capReadyBit,
                            capSide, capHalf};
   wire [7:0] capByte = capHold_r[8*capIdx_r +: 8];
   wire [7:0] rdMux =
      (addr == acp_pkg::OFF_INT_FLAGS) ? flags_r :
      (addr == acp_pkg::OFF_IND_LOW)   ? indReadData[7:0] :
      (addr == acp_pkg::OFF_IND_HIGH)  ? indReadData[15:8] :
      (addr == acp_pkg::OFF_DEBUG)     ? debug_r :
      (addr == acp_pkg::OFF_STATUS)    ? statusByte :
      (addr == acp_pkg::OFF_DATA)      ? capByte :
      (addr == acp_pkg::OFF_PLAY_CFG)  ? cfg_r : acp_pkg::RST_BYTE;
   assign rdData = rd_r;
   // Peak tracking keeps the larger code, cleared by write or power down.
   function automatic logic [1:0] peakMax(input logic [1:0] a, input logic [1:0] b);
      peakMax = (a > b) ? a : b;
   endfunction : peakMax
   wire capFullStuck = !cfInReady && capValid && samplePeriod;
   // A full word still waiting for FIFO room counts as written, so it cannot starve.
   wire playStarved  = !pfOutValid && !playFull_r && pfPop;
   wire playDone     = playWr && playIdx_r == 2'd3;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         flags_r  <= acp_pkg::RST_BYTE;
         lowTmp_r <= acp_pkg::RST_BYTE;
         cfg_r    <= acp_pkg::RST_BYTE;
         rd_r     <= acp_pkg::RST_BYTE;
         ringS1_r <= 1'b0;
         ringS2_r <= 1'b0;
         ringS3_r <= 1'b0;
      end else begin
         flags_r  <= flags_nxt;
         ringS1_r <= ringPin;
         ringS2_r <= ringS1_r;
         ringS3_r <= ringS2_r;
         rd_r     <= rdStrobe ? rdMux : rd_r;
         if (wr && addr == acp_pkg::OFF_IND_LOW) lowTmp_r <= wrData;
         if (wr && addr == acp_pkg::OFF_PLAY_CFG) cfg_r <= wrData;
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn || powerDown || (wr && addr == acp_pkg::OFF_DEBUG)) begin
         debug_r <= acp_pkg::RST_BYTE;
      end else begin
         debug_r[1:0] <= peakMax(debug_r[1:0], leftLevel);
         debug_r[3:2] <= peakMax(debug_r[3:2], rightLevel);
         debug_r[4]   <= capFullStuck || (debug_r[4] && !capRd);
         debug_r[5]   <= (debug_r[5] || playStarved) && !playDone;
         debug_r[7:6] <= 2'b00;
      end
   end
   assign capOver_r   = debug_r[4];
   assign playUnder_r = debug_r[5];
   // Capture byte tracker.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         capLoaded_r <= 1'b0;
         capHold_r   <= '0;
         capIdx_r    <= 2'd0;
         capSt_r     <= acp_pkg::ACP_B0;
      end else if (cfOutValid && cfOutReady) begin
         capLoaded_r <= 1'b1;
         capHold_r   <= cfOut;
         capIdx_r    <= 2'd0;
         capSt_r     <= acp_pkg::ACP_B0;
      end else if (capRd) begin
         case (capSt_r)
            acp_pkg::ACP_B0: begin capSt_r <= acp_pkg::ACP_B1; capIdx_r <= 2'd1; end
            acp_pkg::ACP_B1: begin capSt_r <= acp_pkg::ACP_B2; capIdx_r <= 2'd2; end
            acp_pkg::ACP_B2: begin capSt_r <= acp_pkg::ACP_B3; capIdx_r <= 2'd3; end
            acp_pkg::ACP_B3: capLoaded_r <= 1'b0;
            default: capSt_r <= acp_pkg::ACP_B0;
         endcase
      end
   end
   // Playback byte tracker; the assembled word waits for FIFO room.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         playAsm_r  <= '0;
         playFull_r <= 1'b0;
         playIdx_r  <= 2'd0;
         playSt_r   <= acp_pkg::ACP_B0;
      end else if (pfPush) begin
         playFull_r <= 1'b0;
         playIdx_r  <= 2'd0;
         playSt_r   <= acp_pkg::ACP_B0;
      end else if (playWr && !playFull_r) begin
         playAsm_r[8*playIdx_r +: 8] <= wrData;
         playIdx_r <= playIdx_r + 2'd1;
         case (playSt_r)
            acp_pkg::ACP_B0: playSt_r <= acp_pkg::ACP_B1;
            acp_pkg::ACP_B1: playSt_r <= acp_pkg::ACP_B2;
            acp_pkg::ACP_B2: playSt_r <= acp_pkg::ACP_B3;
            acp_pkg::ACP_B3: playFull_r <= 1'b1;
            default: playSt_r <= acp_pkg::ACP_B0;
         endcase
      end
   end
   // DAC output: first sample of each word; on underrun zero or repeat.
   function automatic logic [15:0] expand(input logic [2:0] f, input logic [7:0] b);
      expand = (f == acp_pkg::FMT_U8) ? {b ^ 8'h80, 8'h00} : {b, 8'h00};
   endfunction : expand
   wire [15:0] wordL = wide ? pfOut[15:0] : expand(fmtCode, pfOut[7:0]);
   wire [15:0] wordR = !pStereo ? wordL :
                       (wide ? pfOut[31:16] : expand(fmtCode, pfOut[15:8]));
   always_ff @(posedge clock) begin
      if (!rstn) begin
         dacL_r <= '0;
         dacR_r <= '0;
         lastWord_r <= '0;
      end else if (pfPop && pfOutValid) begin
         dacL_r <= wordL;
         dacR_r <= wordR;
      end else if (pfPop && dacZero) begin
         dacL_r <= '0;
         dacR_r <= '0;
      end
   end
   assign dacLeft  = dacL_r;
   assign dacRight = dacR_r;
   assign dmaRequest = playback_enable && !pPio && pfInReady &&
                       !(reqDis && flags_r != 8'h00);
   chk_debug_clear: assert property (@(posedge clock) disable iff (!rstn)
      wr && addr == acp_pkg::OFF_DEBUG |=> debug_r == 8'h00)
      else $error("debug not cleared by write");
   chk_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
      !(wr && addr == acp_pkg::OFF_INT_FLAGS) && flags_r[acp_pkg::BIT_TMR]
      |=> flags_r[acp_pkg::BIT_TMR])
      else $error("flag lost without clear");
   chk_timer_raise: assert property (@(posedge clock) disable iff (!rstn)
      timerEvt |=> flags_r[acp_pkg::BIT_TMR])
      else $error("timer flag not raised");
   chk_ind_commit: assert property (@(posedge clock) disable iff (!rstn)
      indWrite |-> wr && addr == acp_pkg::OFF_IND_HIGH)
      else $error("indirect commit without high write");
   chk_dma_gate: assert property (@(posedge clock) disable iff (!rstn)
      dmaRequest |-> playback_enable && !pPio && !(reqDis && flags_r != 8'h00))
      else $error("dma request while gated");
   chk_peak_hold: assert property (@(posedge clock) disable iff (!rstn)
      !powerDown && !(wr && addr == acp_pkg::OFF_DEBUG) ##1 !powerDown
      |-> debug_r[1:0] >= $past(debug_r[1:0]))
      else $error("peak dropped");
   chk_under_clear: assert property (@(posedge clock) disable iff (!rstn)
      playDone && !powerDown |=> !debug_r[5])
      else $error("underrun not cleared");
   chk_cap_hold: assert property (@(posedge clock) disable iff (!rstn)
      capRd && capIdx_r == 2'd3 && !(cfOutValid && cfOutReady) |=> capIdx_r == 2'd3)
      else $error("capture tracker moved past last");
endmodule : acp_host_port

//--- acp_pkg.sv
package acp_pkg;
   localparam logic [3:0] OFF_INT_FLAGS   = 4'h1;
   localparam logic [3:0] OFF_IND_LOW     = 4'h2;
   localparam logic [3:0] OFF_IND_HIGH    = 4'h3;
   localparam logic [3:0] OFF_DEBUG       = 4'h4;
   localparam logic [3:0] OFF_STATUS      = 4'h5;
   localparam logic [3:0] OFF_DATA        = 4'h6;
   localparam logic [3:0] OFF_PLAY_CFG    = 4'h8;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [5:0] DSP_CFG_INDEX   = 6'h21;
   localparam int         DSP_TRIG_BIT    = 13;
   localparam int         FIFO_WORDS      = 8;
   localparam int         FIFO_WIDTH      = 32;
   localparam logic [5:0] HALF_ROOM_BYTES = 6'h20;
   localparam logic [2:0] FMT_U8          = 3'h0;
   localparam logic [2:0] FMT_MULAW       = 3'h1;
   localparam logic [2:0] FMT_S16LE       = 3'h2;
   localparam logic [2:0] FMT_ALAW        = 3'h3;
   // Interrupt flag bit positions.
   localparam int BIT_GAME = 1;
   localparam int BIT_CALL = 2;
   localparam int BIT_DSP  = 3;
   localparam int BIT_VOL  = 4;
   localparam int BIT_TMR  = 5;
   localparam int BIT_CAP  = 6;
   localparam int BIT_PLAY = 7;
   typedef enum logic [3:0] {
      ACP_B0 = 4'b0001,
      ACP_B1 = 4'b0010,
      ACP_B2 = 4'b0100,
      ACP_B3 = 4'b1000
   } acp_byte_e;
endpackage : acp_pkg

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        clock, rstn, rdStrobe, wrStrobe, indWrite, samplePeriod;
   logic        powerDown, capValid, capReady, dmaRequest;
   logic [3:0]  addr, tick;
   logic [7:0]  wrData, rdData, evt, intFlags, rd;
   logic [5:0]  indirectIndex, indAddr;
   logic [15:0] indData, dacLeft, dacRight;
   logic [1:0]  leftLevel, rightLevel;
   logic [31:0] capWord;
   logic [21:0] lastInd;
   int          indCount, fail_count, checks_done;
   acp_host_port uut (.clock(clock), .rstn(rstn), .addr(addr), .rdStrobe(rdStrobe),
      .wrStrobe(wrStrobe), .wrData(wrData), .rdData(rdData), .indirectIndex(indirectIndex),
      .indWrite(indWrite), .indAddr(indAddr), .indData(indData), .indReadData(16'h0000),
      .gameEvt(evt[1]), .ringPin(evt[2]), .volEvt(evt[4]), .timerEvt(evt[5]),
      .capCntEvt(evt[6]), .playCntEvt(evt[7]), .samplePeriod(samplePeriod),
      .leftLevel(leftLevel), .rightLevel(rightLevel), .powerDown(powerDown),
      .capValid(capValid), .capReady(capReady), .capWord(capWord), .dacLeft(dacLeft),
      .dacRight(dacRight), .dmaRequest(dmaRequest), .intFlags(intFlags));
   acp_host_model host (.clock(clock), .addr(addr), .rdStrobe(rdStrobe),
      .wrStrobe(wrStrobe), .wrData(wrData), .rdData(rdData));
   always #5 clock = ~clock;
   always @(posedge clock) begin
      tick         <= tick + 4'h1;
      samplePeriod <= (tick == 4'hf);
      if (indWrite === 1'b1) begin
         indCount <= indCount + 1;
         lastInd  <= {indAddr, indData};
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic expect_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                             input string what);
      host.read_reg(a, rd);
      check(what, e, rd & m);
   endtask : expect_reg
   task automatic pulse(input int i);
      @(posedge clock);
      evt[i] <= 1'b1;
      @(posedge clock);
      evt[i] <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : pulse
   task automatic wait_dac(input logic [15:0] l, input logic [15:0] r);
      int n;
      n = 0;
      while ((dacLeft !== l || dacRight !== r) && n < 300) begin
         @(posedge clock);
         n++;
      end
      check("dacLeft", l, dacLeft);
      check("dacRight", r, dacRight);
      if (dacLeft !== l || dacRight !== r) begin
         stop_test();
      end
   endtask : wait_dac
   task automatic push_cap(input logic [31:0] w);
      int   n;
      logic ok;
      n  = 0;
      ok = 1'b0;
      @(posedge clock);
      capValid <= 1'b1;
      capWord  <= w;
      while (!ok && n < 50) begin
         @(negedge clock);
         ok = (capReady === 1'b1);
         @(posedge clock);
         n++;
      end
      if (!ok) begin
         fail_count++;
         $display("Error capReady timeout");
         stop_test();
      end
      capValid <= 1'b0;
      capWord  <= ~w;
   endtask : push_cap
   task automatic test_reset();
      expect_reg(4'h8, 8'hff, 8'h00, "play cfg reset");
      expect_reg(4'h4, 8'h0f, 8'h00, "debug reset");
      expect_reg(4'h7, 8'hff, 8'h00, "reserved");
      check("flags reset", 8'h00, intFlags);
   endtask : test_reset
   task automatic test_flags();
      logic [7:0] want;
      want = 8'h00;
      for (int i = 1; i < 8; i++) begin
         if (i != 3) begin
            pulse(i);
            want[i] = 1'b1;
            check("flag set", want, intFlags);
         end
      end
      repeat (20) @(posedge clock);
      check("flag sticky", 8'hf6, intFlags);
      host.write_reg(4'h1, 8'hdf);
      expect_reg(4'h1, 8'hff, 8'hd6, "flag clear");
      host.write_reg(4'h1, 8'h00);
   endtask : test_flags
   task automatic test_indirect();
      @(posedge clock);
      indirectIndex <= 6'h05;
      host.write_reg(4'h2, 8'hcd);
      @(posedge clock);
      check("low commit", 0, indCount);
      host.write_reg(4'h3, 8'h20);
      repeat (2) @(posedge clock);
      check("commit", {6'h05, 16'h20cd}, lastInd);
      check("no dsp flag", 8'h00, intFlags);
      indirectIndex <= acp_pkg::DSP_CFG_INDEX;
      host.write_reg(4'h2, 8'h00);
      host.write_reg(4'h3, 8'h20);
      repeat (2) @(posedge clock);
      check("dsp flag", 8'h08, intFlags);
      host.write_reg(4'h1, 8'h00);
   endtask : test_indirect
   task automatic test_peak();
      @(posedge clock);
      leftLevel  <= 2'h2;
      rightLevel <= 2'h3;
      repeat (40) @(posedge clock);
      leftLevel  <= 2'h1;
      rightLevel <= 2'h0;
      repeat (40) @(posedge clock);
      leftLevel  <= 2'h0;
      expect_reg(4'h4, 8'h0f, 8'h0e, "peak hold");
      host.write_reg(4'h4, 8'hff);
      expect_reg(4'h4, 8'hff, 8'h00, "debug cleared");
      leftLevel  <= 2'h3;
      repeat (40) @(posedge clock);
      expect_reg(4'h4, 8'h03, 8'h03, "peak left max");
      leftLevel  <= 2'h0;
      powerDown  <= 1'b1;
      repeat (4) @(posedge clock);
      powerDown  <= 1'b0;
      expect_reg(4'h4, 8'h0f, 8'h00, "peak powerdown");
   endtask : test_peak
   task automatic test_playback();
      logic [7:0] c;
      for (int i = 0; i < 4; i++) begin
         c = {2'b00, i[2:1], i[0], 3'b011};
         host.write_reg(4'h8, c);
         expect_reg(4'h8, 8'hff, c, "format code");
      end
      expect_reg(4'h5, 8'h30, 8'h30, "mono halves");
      host.write_reg(4'h8, 8'h17);
      expect_reg(4'h5, 8'h30, 8'h20, "left low");
      host.write_reg(4'h6, 8'h34);
      host.write_reg(4'h6, 8'h12);
      expect_reg(4'h5, 8'h30, 8'h00, "right low");
      host.write_reg(4'h6, 8'h78);
      expect_reg(4'h5, 8'h30, 8'h10, "right high");
      host.write_reg(4'h6, 8'h56);
      wait_dac(16'h1234, 16'h5678);
      repeat (100) @(posedge clock);
      expect_reg(4'h4, 8'h20, 8'h20, "underrun");
      check("repeat last", 16'h1234, dacLeft);
      host.write_reg(4'h8, 8'h07);
      expect_reg(4'h5, 8'h30, 8'h30, "u8 left first");
      host.write_word(32'h00ff4080);
      wait_dac(16'h0000, 16'hc000);
      host.write_reg(4'h8, 8'h57);
      wait_dac(16'h0000, 16'h0000);
      host.write_word(32'h56781234);
      expect_reg(4'h4, 8'h20, 8'h00, "underrun clear");
      host.write_reg(4'h8, 8'h01);
      repeat (4) @(posedge clock);
      check("dma req", 1'b1, dmaRequest);
      pulse(5);
      check("dma pending", 1'b1, dmaRequest);
      host.write_reg(4'h8, 8'h81);
      repeat (2) @(posedge clock);
      check("dma blocked", 1'b0, dmaRequest);
      host.write_reg(4'h8, 8'h03);
      repeat (2) @(posedge clock);
      check("pio no dma", 1'b0, dmaRequest);
      host.write_reg(4'h8, 8'h00);
      host.write_reg(4'h1, 8'h00);
   endtask : test_playback
   task automatic test_capture();
      push_cap(32'hd4c3b2a1);
      repeat (4) @(posedge clock);
      expect_reg(4'h5, 8'h04, 8'h04, "data ready");
      for (int b = 0; b < 5; b++) begin
         expect_reg(4'h6, 8'hff, (b < 4) ? 8'(8'ha1 + 8'h11 * b) : 8'hd4, "cap byte");
      end
      expect_reg(4'h5, 8'h04, 8'h00, "stale");
      for (int j = 0; j < 9; j++) begin
         push_cap({8'(j * 16 + 3), 8'(j * 16 + 2), 8'(j * 16 + 1), 8'(j * 16)});
      end
      @(posedge clock);
      check("fifo full", 1'b0, capReady);
      expect_reg(4'h5, 8'h0c, 8'h04, "full status");
      push_cap(32'hffffffff);
      repeat (60) @(posedge clock);
      expect_reg(4'h4, 8'h10, 8'h10, "overrun");
      for (int j = 0; j < 9; j++) begin
         for (int b = 0; b < 4; b++) begin
            expect_reg(4'h6, 8'hff, 8'(j * 16 + b), "drain byte");
         end
         if (j == 0) expect_reg(4'h4, 8'h10, 8'h00, "overrun clear");
      end
      expect_reg(4'h5, 8'h0c, 8'h08, "empty");
   endtask : test_capture
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      tick = 4'h0;
      samplePeriod = 1'b0;
      evt = 8'h00;
      indirectIndex = 6'h00;
      leftLevel = 2'h0;
      rightLevel = 2'h0;
      powerDown = 1'b0;
      capValid = 1'b0;
      capWord = 32'h0;
      indCount = 0;
      fail_count = 0;
      checks_done = 0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      test_reset();
      test_flags();
      test_indirect();
      test_peak();
      test_playback();
      test_capture();
      stop_test();
   end
endmodule : testbench
